// *** inc/aigc_pkg.sv ***
// shared constants and carrier types for the interleave/gain control
package aigc_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PAR  = 8'h04;
  localparam logic [7:0] A_REF  = 8'h08;
  localparam logic [7:0] A_NS   = 8'h0C;
  localparam logic [7:0] A_GAIN = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  // control and reference register field positions
  localparam int B_PAIR  = 0;
  localparam int B_PREG  = 1;
  localparam int B_UPPER = 4;
  localparam int B_EXTR  = 15;
  // status register field positions
  localparam int S_PAIR  = 0;
  localparam int S_EVEN  = 1;
  localparam int S_PHASE = 2;
  localparam int S_EXTR  = 3;
  localparam int S_PIN   = 4;
  // parity select register values
  localparam logic [15:0] PAR_ODD  = 16'h8000;
  localparam logic [15:0] PAR_EVEN = 16'h80FF;
  // reset values
  localparam logic [15:0] PAR_RST  = PAR_ODD;
  localparam logic [31:0] GAIN_RST = 32'h0000_0000;
  localparam logic        PIN_RST  = 1'b1;
  // channel count, sample width, gain code range
  localparam int         NCH      = 8;
  localparam int         DW       = 12;
  localparam logic [3:0] GAIN_MAX = 4'hC;
  localparam int         GFRAC    = 10;
  // gain factors 10^(g/20) in unsigned q2.10
  localparam logic [12:0] GTAB [0:12] = '{
    13'h0400, 13'h047D, 13'h0509, 13'h05A6, 13'h0657,
    13'h071D, 13'h07FB, 13'h08F4, 13'h0A0C, 13'h0B46,
    13'h0CA6, 13'h0E31, 13'h0FEC};
  // apb request and answer
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } aigc_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } aigc_apb_rsp_t;
  // complete state of the control block
  typedef struct packed {
    logic              pair_en;
    logic              par_reg_en;
    logic              upper_en;
    logic [15:0]       par_val;
    logic              ext_ref;
    logic [NCH-1:0]    ns_en;
    logic [31:0]       gain;
    logic              act_pair;
    logic              act_even;
    logic              phase;
    logic [NCH-1:0]    flip;
    logic [NCH-1:0]    vld;
    logic [NCH*DW-1:0] lane;
    logic [31:0]       rdata;
    logic              err;
  } aigc_st_t;
endpackage

// *** logic/aigc_ctrl.sv ***
// interleave, parity mapping, gain and reference control with apb
`timescale 1ns/1ns
module aigc_ctrl
  import aigc_pkg::*;
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire aigc_pkg::aigc_apb_req_t  apb_i,
  output aigc_pkg::aigc_apb_rsp_t       apb_o,
  input  wire logic                     parity_select_pin_i,
  input  wire logic                     sync_i,
  input  wire logic [95:0]              conv_data_i,
  output logic      [7:0]               conv_smp_o,
  output logic                          samp_odd_o,
  output logic                          samp_even_o,
  output logic                          in_even_o,
  output logic      [7:0]               noise_chop_o,
  output logic                          int_ref_pd_o,
  output logic      [7:0]               lane_vld_o,
  output logic      [95:0]              lane_data_o
);
  import aigc_pkg::*;

  aigc_st_t         st_r;        // registered state
  aigc_st_t         st_nxt;      // next state
  logic             pin_s;       // synchronised parity pin
  logic             sync_s;      // synchronised phase align
  logic             want_even;   // requested parity source
  logic             wr;          // apb write in access phase
  logic             setup;       // apb setup phase
  logic [DW-1:0]    mapd [NCH];  // lane input after mapping
  logic [DW-1:0]    gnd  [NCH];  // lane input after gain
  logic [NCH-1:0]   smp;         // converter sample strobes

  // parity pin is pulled up, so idle and reset read high
  aigc_sync #(
    .W  (1),
    .RV (PIN_RST)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (parity_select_pin_i),
    .q_o        (pin_s)
  );

  // phase align input from another chip's controller
  aigc_sync #(
    .W  (1),
    .RV (1'b0)
  ) u_align_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        (sync_i),
    .q_o        (sync_s)
  );

  // per-lane mapping and gain
  genvar k;
  generate
    for (k = 0; k < NCH; k++)
    begin : g_lane
      // interleave keeps lanes; eight-channel may swap pairs
      // lane k is converter k while pairs run; the analog mux
      // ahead of the converters picks the odd or even inputs
      assign mapd[k] = (!st_r.act_pair && st_r.act_even)
                     ? conv_data_i[(k^1)*DW +: DW]
                     : conv_data_i[k*DW +: DW];
      aigc_gain u_gain (
        .d_i    (mapd[k]),
        .code_i (st_r.gain[k*4 +: 4]),
        .q_o    (gnd[k])
      );
      // pair members alternate on the halved phase
      assign smp[k] = st_r.act_pair
                    ? (st_r.phase == 1'(k % 2))
                    : 1'b1;
    end
  endgenerate

  // apb phase decode
  assign setup = apb_i.psel && !apb_i.penable;
  assign wr    = apb_i.psel && apb_i.penable && apb_i.pwrite;

  // parity request: the control bit hands the choice to the pin;
  // it is clear after reset, so pairs start on the odd inputs
  assign want_even = st_r.par_reg_en
                   ? pin_s
                   : (st_r.par_val == PAR_EVEN);

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    // halved clock toggles; sync holds it at the odd phase
    if (sync_s)
      st_nxt.phase = 1'b0;
    else
      st_nxt.phase = !st_r.phase;
    // new mode only at the end of a pair period
    if (st_r.phase)
    begin
      st_nxt.act_pair = st_r.pair_en;
      st_nxt.act_even = want_even;
    end
    // register writes in the access phase
    if (wr)
    begin
      unique case (apb_i.paddr)
        A_CTRL:
        begin
          st_nxt.pair_en    = apb_i.pwdata[B_PAIR];
          st_nxt.par_reg_en = apb_i.pwdata[B_PREG];
          st_nxt.upper_en   = apb_i.pwdata[B_UPPER];
        end
        A_PAR:
          st_nxt.par_val = apb_i.pwdata[15:0];
        A_REF:
        begin
          // locked until the upper map is opened
          if (st_r.upper_en)
            st_nxt.ext_ref = apb_i.pwdata[B_EXTR];
        end
        A_NS:
          st_nxt.ns_en = apb_i.pwdata[NCH-1:0];
        A_GAIN:
          st_nxt.gain = apb_i.pwdata;
        default:
          st_nxt.err = st_r.err;                       // unmapped
      endcase
    end
    // read data and error captured at setup
    if (setup)
    begin
      st_nxt.rdata = '0;
      st_nxt.err   = 1'b0;
      unique case (apb_i.paddr)
        A_CTRL:
        begin
          st_nxt.rdata[B_PAIR]  = st_r.pair_en;
          st_nxt.rdata[B_PREG]  = st_r.par_reg_en;
          st_nxt.rdata[B_UPPER] = st_r.upper_en;
        end
        A_PAR:
          st_nxt.rdata[15:0] = st_r.par_val;
        A_REF:
          st_nxt.rdata[B_EXTR] = st_r.upper_en && st_r.ext_ref;
        A_NS:
          st_nxt.rdata[NCH-1:0] = st_r.ns_en;
        A_GAIN:
          st_nxt.rdata = st_r.gain;
        // status shows the modes in force, not the requested ones
        A_STAT:
        begin
          st_nxt.rdata[S_PAIR]  = st_r.act_pair;
          st_nxt.rdata[S_EVEN]  = st_r.act_even;
          st_nxt.rdata[S_PHASE] = st_r.phase;
          st_nxt.rdata[S_EXTR]  = int_ref_pd_o;
          st_nxt.rdata[S_PIN]   = pin_s;
        end
        default:
          st_nxt.err = 1'b1;                           // unmapped
      endcase
    end
    // lane outputs: gain, then noise shift chopping
    for (int i = 0; i < NCH; i++)
    begin
      st_nxt.vld[i] = smp[i];
      if (smp[i])
      begin
        // enabled lanes alternate sign each sample
        if (st_r.ns_en[i] && st_r.flip[i])
          st_nxt.lane[i*DW +: DW] =
            (gnd[i] == 12'h800) ? 12'h7FF : 12'(-gnd[i]);
        else
          st_nxt.lane[i*DW +: DW] = gnd[i];
        st_nxt.flip[i] = st_r.ns_en[i] && !st_r.flip[i];
      end
    end
  end

  // state register, reset restores defaults
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r            <= '0;
      st_r.par_val    <= PAR_RST;
      st_r.gain       <= GAIN_RST;
      st_r.act_even   <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // outputs
  // zero wait states: ready in every access cycle
  assign apb_o.pready  = apb_i.psel && apb_i.penable;
  assign apb_o.pslverr = apb_i.psel && apb_i.penable && st_r.err;
  assign apb_o.prdata  = st_r.rdata;
  assign conv_smp_o    = smp;
  assign samp_odd_o    = !st_r.phase;
  assign samp_even_o   = st_r.phase;
  // pairs fed from odd or even analog inputs
  assign in_even_o     = st_r.act_pair && st_r.act_even;
  assign noise_chop_o  = st_r.ns_en & st_r.flip;
  // both enables needed; powers down the internal reference
  assign int_ref_pd_o  = st_r.upper_en && st_r.ext_ref;
  assign lane_vld_o    = st_r.vld;
  assign lane_data_o   = st_r.lane;

  // checks: phase, strobes, mode timing, mapping, gain, reference;
  // lane 0 stands in for the other seven, which share its logic
  chk_phase_toggle: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !sync_s |=> st_r.phase != $past(st_r.phase))
    else $error("halved phase did not toggle");

  chk_clk_opposite: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_r.act_pair |-> conv_smp_o == {4{samp_even_o, samp_odd_o}})
    else $error("sampling clocks not opposite");

  chk_pair_strobe: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_r.act_pair |-> conv_smp_o == (st_r.phase ? 8'hAA : 8'h55))
    else $error("pair strobes wrong phase");

  chk_mode_edge: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ($changed(st_r.act_pair) || $changed(st_r.act_even))
      |-> $past(st_r.phase))
    else $error("mode changed mid pair");

  chk_ref_lock: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (wr && apb_i.paddr == A_REF && !st_r.upper_en && !st_r.ext_ref)
      |=> !int_ref_pd_o)
    else $error("reference entered without upper map");

  chk_gain_reset: assert property (
    @(posedge core_clk_i)
    !rst_n_i |=> st_r.gain == GAIN_RST)
    else $error("gain not zero after reset");

  chk_straight_map: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!st_r.act_pair && !st_r.act_even && st_r.gain == 32'h0
      && st_r.ns_en == 8'h00)
      |=> lane_data_o[11:0] == $past(conv_data_i[11:0]))
    else $error("straight map broken");

  chk_swap_map: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!st_r.act_pair && st_r.act_even && st_r.gain == 32'h0
      && st_r.ns_en == 8'h00)
      |=> lane_data_o[11:0] == $past(conv_data_i[23:12]))
    else $error("swap map broken");

  chk_pin_parity: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (st_r.par_reg_en && st_r.phase && !wr)
      |=> st_r.act_even == $past(pin_s))
    else $error("pin parity not applied");

  chk_even_select: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!st_r.par_reg_en && st_r.par_val == PAR_EVEN && st_r.phase)
      |=> st_r.act_even)
    else $error("even register value not applied");

  chk_odd_select: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!st_r.par_reg_en && st_r.par_val != PAR_EVEN && st_r.phase)
      |=> !st_r.act_even)
    else $error("odd register value not applied");

  chk_gain_sign: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (smp[0] && !st_r.ns_en[0])
      |=> lane_data_o[DW-1] == $past(mapd[0][DW-1]))
    else $error("gain changed the sample sign");

  chk_gain_unity: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (smp[0] && !st_r.ns_en[0] && st_r.gain[3:0] == 4'h0)
      |=> lane_data_o[DW-1:0] == $past(mapd[0]))
    else $error("zero gain code altered the sample");

  chk_shift_toggle: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (smp[0] && st_r.ns_en[0])
      |=> st_r.flip[0] != $past(st_r.flip[0]))
    else $error("noise shift did not alternate");

  chk_phase_hold: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    sync_s |=> !st_r.phase)
    else $error("phase not held by align input");

  chk_ref_write: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(int_ref_pd_o) |-> $past(wr))
    else $error("reference mode entered without a write");

  // cover the main operating modes
  cov_interleave: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_r.act_pair && !st_r.act_even);
  cov_even_pair: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    st_r.act_pair && st_r.act_even);
  cov_swap_map: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !st_r.act_pair && st_r.act_even);
  cov_ext_ref: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(int_ref_pd_o));
  cov_gain_sat: cover property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    lane_vld_o[0] && lane_data_o[11:0] == 12'h7FF);
endmodule

// *** logic/aigc_gain.sv ***
// saturating digital gain for one sample
`timescale 1ns/1ns
module aigc_gain
  import aigc_pkg::*;
(
  input  wire logic signed [aigc_pkg::DW-1:0] d_i,
  input  wire logic        [3:0]              code_i,
  output logic signed      [aigc_pkg::DW-1:0] q_o
);
  import aigc_pkg::*;

  logic        [3:0]    c;    // code, illegal ones held at top
  logic signed [26:0]   p;    // full product
  logic signed [26:0]   s;    // product back in sample units
  localparam logic signed [26:0] PMAX = 27'sd2047;
  localparam logic signed [26:0] PMIN = -27'sd2048;
  // codes above twelve must not be used; clip to twelve
  always_comb
  begin
    c = (code_i > GAIN_MAX) ? GAIN_MAX : code_i;
    p = 27'(d_i) * $signed({1'b0, GTAB[c]});
    s = p >>> GFRAC;
    // clip, never wrap
    if (s > PMAX)
      q_o = 12'sh7FF;
    else if (s < PMIN)
      q_o = -12'sh800;
    else
      q_o = s[DW-1:0];
  end
endmodule

// *** logic/aigc_sync.sv ***
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module aigc_sync #(
  parameter int         W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] m_r;  // first stage, read only by q_o flop
  // two stages, reset to the pin's idle level
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      m_r <= RV;
      q_o <= RV;
    end
    else
    begin
      m_r <= d_i;
      q_o <= m_r;
    end
  end
endmodule

// *** tb/adc_interleave_gain_control_bench.sv ***
// self-checking bench for the interleave, mapping, gain and reference block
`timescale 1ns/1ns
module adc_interleave_gain_control_bench;
  import aigc_pkg::*;
  logic          core_clk = 1'b0; // device clock
  logic          rst_n    = 1'b0; // reset, active low
  aigc_apb_req_t apb_req  = '0;   // bus request
  aigc_apb_rsp_t apb_rsp;         // bus answer
  logic          par_pin  = 1'b1; // parity pin level, pulled-up idle
  logic          sync     = 1'b0; // phase hold input
  logic [95:0]   conv     = '0;   // converter samples
  logic [7:0]    smp, chop, vld;  // strobes, chop state, lane valid
  logic          s_odd, s_even, in_even, ref_pd;
  logic [95:0]   lanes;           // lane samples
  int            merged;          // samples merged by the receiver
  logic          ord_err;         // receiver saw a broken order
  int            bad_count = 0;
  int            n_tests   = 0;
  int            seed      = 18;
  logic [31:0]   gains     = '0;  // gain codes now in the device
  logic [31:0]   q;
  logic          e;
  int            m, i;
  logic [7:0]    acc;

  aigc_ctrl u_aigc_ctrl (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .apb_i(apb_req), .apb_o(apb_rsp), .parity_select_pin_i(par_pin),
    .sync_i(sync), .conv_data_i(conv), .conv_smp_o(smp),
    .samp_odd_o(s_odd), .samp_even_o(s_even), .in_even_o(in_even),
    .noise_chop_o(chop), .int_ref_pd_o(ref_pd), .lane_vld_o(vld),
    .lane_data_o(lanes));
  aigc_rx_model u_aigc_rx_model (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .lane_vld_i(vld), .merged_o(merged), .order_err_o(ord_err));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // compare one value and count the outcome
  task automatic check(input string what, input logic [95:0] seen,
                       input logic [95:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // print counts and verdict, then end the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int k;
    @(posedge core_clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge core_clk);
      if (apb_rsp.pready === 1'b1)
        break;
    end
    if (k == 16)
    begin
      bad_count++;
      stop_test();
    end
    rq = apb_rsp.prdata;
    re = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // expected sample after gain, saturated to 12 bits
  function automatic logic [11:0] gexp(input logic [11:0] x,
                                       input logic [3:0] g);
    int p;
    int f;
    f = GTAB[(g > GAIN_MAX) ? GAIN_MAX : g];
    p = int'($signed(x)) * f;
    p = p >>> GFRAC;
    if (p > 2047)
      p = 2047;
    if (p < -2048)
      p = -2048;
    return p[11:0];
  endfunction

  // expected lanes for a mapping mode
  function automatic logic [95:0] lexp(input logic p, input logic ev,
                                       input logic [95:0] c);
    logic [95:0] r;
    int k, s;
    for (k = 0; k < 8; k++)
    begin
      s = (!p && ev) ? k ^ 1 : k;
      r[12*k +: 12] = gexp(c[12*s +: 12], gains[4*k +: 4]);
    end
    return r;
  endfunction

  // set mode by register or pin, the other source set the opposite way
  task automatic set_mode(input logic p, input logic r, input logic s);
    int k;
    apb(1'b1, A_PAR, (s ^ r) ? PAR_EVEN : PAR_ODD, q, e);
    apb(1'b1, A_CTRL, {30'h0, r, p}, q, e);
    par_pin <= s ^ ~r;
    for (k = 0; k < 20; k++)
    begin
      apb(1'b0, A_STAT, 32'h0, q, e);
      if (q[1:0] == {s, p})
        break;
    end
    check("mode", q[1:0], {s, p});
  endtask

  // drive samples, hold them and check lanes, strobes and phases
  task automatic data_check(input logic p, input logic s,
                            input logic corner);
    logic [95:0] c;
    logic        po;
    for (i = 0; i < 3; i++)
      c[32*i +: 32] = $random(seed);
    if (corner)
      c = {4{12'h800, 12'h7FF}};
    @(posedge core_clk);
    conv <= c;
    repeat (3) @(posedge core_clk);
    #1;
    check("lanes", lanes, lexp(p, s, c));
    check("in_even", in_even, p & s);
    check("strobe", smp, p ? (s_odd ? 8'h55 : 8'hAA) : 8'hFF);
    if (p)
    begin
      check("vld", vld, s_even ? 8'h55 : 8'hAA);
      po = s_odd;
      @(posedge core_clk);
      #1;
      check("phase", {s_odd, s_even}, {~po, po});
    end
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    check("rst_phase", {s_odd, s_even, smp}, {2'b10, 8'hFF});
    apb(1'b0, A_PAR, 32'h0, q, e);
    check("par_rst", q, {16'h0, PAR_RST});
    apb(1'b0, A_GAIN, 32'h0, q, e);
    check("gain_rst", q, GAIN_RST);
    apb(1'b0, A_REF, 32'h0, q, e);
    check("ref_rst", q, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check("unmapped", e, 1'b1);
    // reference register stays closed until the upper map is open
    apb(1'b1, A_REF, 32'h8000, q, e);
    apb(1'b0, A_REF, 32'h0, q, e);
    check("ref_closed", {q, ref_pd}, 33'h0);
    apb(1'b1, A_CTRL, 32'h11, q, e);
    apb(1'b1, A_REF, 32'h8000, q, e);
    #1;
    check("ref_on", ref_pd, 1'b1);
    apb(1'b1, A_REF, 32'h0, q, e);
    #1;
    check("ref_off", ref_pd, 1'b0);
    // pairs start on the odd inputs even with the pin pulled high
    apb(1'b0, A_STAT, 32'h0, q, e);
    check("odd_default", q[1:0], 2'b01);
    // every mode, by register and by pin, at 0 dB then random gain
    for (m = 0; m < 8; m++)
    begin
      set_mode(m[0], m[1], m[2]);
      gains = GAIN_RST;
      apb(1'b1, A_GAIN, gains, q, e);
      data_check(m[0], m[2], 1'b0);
      for (i = 0; i < 8; i++)
        gains[4*i +: 4] = 4'($unsigned($random(seed)) % 13);
      apb(1'b1, A_GAIN, gains, q, e);
      data_check(m[0], m[2], 1'b0);
      $display("test mode %0d done", m);
    end
    // unused codes and full-scale samples must clip, not wrap
    gains = 32'hFFFF_CCCC;
    apb(1'b1, A_GAIN, gains, q, e);
    data_check(1'b1, 1'b1, 1'b1);
    check("merge", {ord_err, merged > 0}, 2'b01);
    // noise shift only on enabled channels, and it does toggle
    apb(1'b1, A_NS, 32'h5A, q, e);
    acc = '0;
    for (i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      #1;
      acc = acc | chop;
    end
    check("chop", acc, 8'h5A);
    $display("test noise shift done");
    // phase hold keeps the odd clock high
    @(posedge core_clk);
    sync <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    check("sync", s_odd, 1'b1);
    @(posedge core_clk);
    sync <= 1'b0;
    #1;
    check("sync_hold", s_odd, 1'b1);
    $display("test sync done");
    stop_test();
  end
endmodule

// *** tb/aigc_rx_model.sv ***
// receiver model that merges the two lanes of interleaved pair 0
`timescale 1ns/1ns
module aigc_rx_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] lane_vld_i,
  output int              merged_o,
  output logic            order_err_o
);
  logic last_r; // lane that gave the previous merged sample
  // take lanes 0 and 1 in turn into one full-rate stream
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      merged_o    <= 0;
      order_err_o <= 1'b0;
      last_r      <= 1'b1;
    end
    else if (lane_vld_i[1:0] == 2'b01 || lane_vld_i[1:0] == 2'b10)
    begin
      merged_o <= merged_o + 1;
      // the same lane twice in a row breaks the stream order
      if (lane_vld_i[1] == last_r)
        order_err_o <= 1'b1;
      last_r <= lane_vld_i[1];
    end
endmodule
